// *** rtl/mss_top.sv ***
// Summary of operation
// R01 - sync output low when idle, high for exactly the sag duration
// R02 - single sag first-use defaults are 5 ms delay and 100 ms duration
// R03 - parameters are kept after each test and reused next time
// R04 - start command cuts load supply per programmed delay and duration
// R05 - soak dips are separated by an interval, first-use 10 s
// R06 - soak first dip length defaults to 100 ms
// R07 - soak last dip length defaults to 1000 ms
// R08 - soak step count defaults to 200
// R09 - each step has 20 dips, the first starting at zero crossing
// R10 - each later dip starts one twentieth period later than previous
// R11 - interrupting soak pauses it; resumes alone after 30 s
// R12 - stop while paused abandons the soak and returns to idle
// R13 - dips done, total dips and time left are readable
// R14 - power-on check flags bad mains frequency or overload
// R15 - an error shuts down and stays latched until power cycle
// R16 - variable-output mode holds until power is cycled
// R17 - left/right pick the edited digit, up/down change it
// R18 - sag duration accepted only from 10 to 9999 ms
// R19 - crossing and period come from the mains polarity signal
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module mss_top import mss_pkg::*; #(
    parameter int CYC_PER_MS = MS_CYC,
    parameter int PER50 = PER50_CYC,
    parameter int PER60 = PER60_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic mains_pol,
    input wire logic overload,
    output logic sync_out,
    output logic load_on,
    output logic variac_on,
    output logic err_freq,
    output logic err_overload,
    output logic shutdown,
    output logic [1:0] digit_sel
);

    typedef struct packed {
        mss_state_t st;
        logic waitreq;
        logic [31:0] rdata;
        logic sync;
        logic load;
        logic variac;
        logic e_freq;
        logic e_ovl;
        logic down;
        logic armed;
        logic [NPAR-1:0][15:0] par;
        logic [1:0] digit;
        logic [27:0] cyc;
        logic [23:0] ms;
        logic [4:0] dip_idx;
        logic [15:0] step;
        logic [19:0] dips;
        logic [15:0] dur;
        logic [25:0] acc;
    } mss_regs_t;

    mss_regs_t s, n;
    logic ms_tick;
    logic zc;
    logic [19:0] period;
    logic freq_ok;
    logic take;
    logic [15:0] cmd;
    logic [2:0] widx;
    logic [15:0] wval;
    logic [20:0] total;
    logic [20:0] left_dips;

    mss_tick #(.DIV(CYC_PER_MS)) u_tick (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(ms_tick)
    );

    mss_zc #(.PER50(PER50), .PER60(PER60)) u_zc (
        .clock(clock),
        .sys_rst(sys_rst),
        .mains_pol(mains_pol),
        .zc(zc),
        .period(period),
        .freq_ok(freq_ok)
    );

    // ==========================================================
    // helpers
    function automatic logic [2:0] mss_par_idx(input logic [7:0] a);
        if (a >= OFS_DELAY && a <= OFS_STEPS && a[1:0] == 2'h0) begin
            return 3'((a - OFS_DELAY) >> 2);
        end
        return 3'h7;
    endfunction

    function automatic logic [15:0] mss_clamp(input int i,
                                              input logic [17:0] v);
        logic [17:0] lo;
        logic [17:0] hi;
        lo = (i == PAR_DUR) ? 18'(DUR_MIN) :
             (i == PAR_STEPS) ? 18'(STEPS_MIN) : 18'h0;
        hi = (i == PAR_DELAY) ? 18'(DELAY_MAX) :
             (i == PAR_DUR) ? 18'(DUR_MAX) : 18'(PAR_MAX);
        if ($signed(v) < $signed(lo)) begin
            return lo[15:0];
        end
        if ($signed(v) > $signed(hi)) begin
            return hi[15:0];
        end
        return v[15:0];
    endfunction

    function automatic logic [17:0] mss_weight(input logic [1:0] d);
        case (d)
            2'h0: return 18'h00001;
            2'h1: return 18'h0000a;
            2'h2: return 18'h00064;
            default: return 18'h003e8;
        endcase
    endfunction

    // dip length for a step, linear from first to last
    function automatic logic [15:0] mss_lerp(input logic [15:0] f,
                                             input logic [15:0] l,
                                             input logic [15:0] k,
                                             input logic [15:0] steps);
        logic signed [33:0] d;
        if (steps <= STEPS_MIN) begin
            return f;
        end
        d = ($signed({18'h0, l}) - $signed({18'h0, f}))
            * $signed({18'h0, k});
        d = d / $signed({18'h0, steps - 16'h0001});
        return 16'($signed({18'h0, f}) + d);
    endfunction

    assign take = !s.waitreq && (avs_read || avs_write);
    assign widx = mss_par_idx(avs_address);
    assign wval = {avs_byteenable[1] ? avs_writedata[15:8]
                       : s.par[widx][15:8],
                   avs_byteenable[0] ? avs_writedata[7:0]
                       : s.par[widx][7:0]};
    assign cmd = (take && avs_write && avs_address == OFS_CMD)
        ? avs_writedata[15:0] & {{8{avs_byteenable[1]}},
                                 {8{avs_byteenable[0]}}}
        : 16'h0;
    assign total = 21'(s.par[PAR_STEPS] * DIPS_PER_STEP);
    assign left_dips = total - 21'(s.dips);

    // ==========================================================
    // bus slave, parameter edits and sequencer
    always_comb begin
        n = s;
        // one wait cycle, then the request is taken
        n.waitreq = !((avs_read || avs_write) && s.waitreq);
        if ((avs_read || avs_write) && s.waitreq) begin
            case (avs_address)
                OFS_STATUS: n.rdata = 32'({s.digit, s.down, s.e_ovl,
                    s.e_freq, s.variac, s.load, s.sync, s.st});
                OFS_DIPS: n.rdata = 32'(s.dips); // [R13]
                OFS_TOTAL: n.rdata = 32'(total); // [R13]
                OFS_TLEFT: n.rdata = 32'(left_dips * s.par[PAR_INT]);
                default: n.rdata = (widx != 3'h7)
                    ? 32'(s.par[widx]) : 32'h0;
            endcase
        end
        // parameters persist across tests and reset only at power-up
        if (take && avs_write && widx != 3'h7) begin // [R03]
            n.par[widx] = mss_clamp(int'(widx), {2'h0, wval}); // [R18]
        end
        if (cmd[CMD_LEFT] && s.digit != 2'h3) begin // [R17]
            n.digit = s.digit + 2'h1;
        end
        if (cmd[CMD_RIGHT] && s.digit != 2'h0) begin // [R17]
            n.digit = s.digit - 2'h1;
        end
        if ((cmd[CMD_UP] || cmd[CMD_DOWN])
                && cmd[CMD_SEL+:3] < 3'(NPAR)) begin
            n.par[cmd[CMD_SEL+:3]] = mss_clamp(int'(cmd[CMD_SEL+:3]),
                cmd[CMD_UP]
                ? {2'h0, s.par[cmd[CMD_SEL+:3]]} + mss_weight(s.digit)
                : {2'h0, s.par[cmd[CMD_SEL+:3]]} - mss_weight(s.digit));
        end
        if (ms_tick) begin
            n.ms = s.ms + 24'h000001;
        end
        case (s.st)
            ST_CHECK: begin
                if (s.ms >= CHECK_MS) begin // [R14]
                    if (!freq_ok || overload) begin
                        n.st = ST_FAULT; // [R15]
                        n.e_freq = !freq_ok;
                        n.e_ovl = overload;
                        n.down = 1'b1;
                    end else begin
                        n.st = ST_IDLE;
                        n.load = 1'b1;
                    end
                end
            end
            ST_IDLE: begin
                n.sync = 1'b0; // [R01]
                if (cmd[CMD_VARIAC]) begin
                    n.st = ST_VARIAC; // [R16]
                    n.variac = 1'b1;
                    n.load = 1'b0;
                end else if (cmd[CMD_SAG]) begin
                    n.st = ST_SAG_WAIT; // [R04]
                    n.armed = 1'b0;
                end else if (cmd[CMD_SOAK]) begin
                    n.st = ST_SOAK_ZC;
                    n.step = '0;
                    n.dip_idx = '0;
                    n.dips = '0;
                    n.dur = s.par[PAR_FIRST]; // [R06]
                end
            end
            ST_SAG_WAIT: begin
                n.cyc = s.cyc + 28'h1;
                if (!s.armed) begin
                    if (zc) begin // [R19]
                        n.armed = 1'b1;
                        n.cyc = '0;
                    end
                end else if (s.cyc + 28'h1 >=
                             28'(s.par[PAR_DELAY] * CYC_PER_10US)) begin
                    n.st = ST_SAG_ON; // [R04]
                    n.sync = 1'b1; // [R01]
                    n.load = 1'b0;
                    n.cyc = '0;
                end
            end
            ST_SAG_ON: begin
                n.cyc = s.cyc + 28'h1;
                if (s.cyc + 28'h1 >= 28'(s.par[PAR_DUR] * CYC_PER_MS)) begin
                    n.st = ST_IDLE;
                    n.sync = 1'b0; // [R01]
                    n.load = 1'b1;
                end
            end
            ST_SOAK_GAP: begin
                if (s.ms >= 24'(s.par[PAR_INT] * MS_PER_S)) begin // [R05]
                    n.st = ST_SOAK_ZC;
                end
            end
            ST_SOAK_ZC: begin
                if (zc) begin // [R09]
                    n.st = ST_SOAK_DLY;
                    n.acc = '0;
                end
            end
            ST_SOAK_DLY: begin
                // acc grows 20 per cycle, so it reaches period*k
                // after period*k/20 cycles without a divider
                n.acc = s.acc + 26'(PHASE_INC);
                if (s.acc >= 26'(period * s.dip_idx)) begin // [R10]
                    n.st = ST_SOAK_DIP;
                    n.sync = 1'b1;
                    n.load = 1'b0;
                    n.cyc = '0;
                end
            end
            ST_SOAK_DIP: begin
                n.cyc = s.cyc + 28'h1;
                if (s.cyc + 28'h1 >= 28'(s.dur * CYC_PER_MS)) begin
                    n.sync = 1'b0;
                    n.load = 1'b1;
                    n.dips = s.dips + 20'h1; // [R13]
                    n.ms = '0;
                    n.st = ST_SOAK_GAP;
                    n.dip_idx = s.dip_idx + 5'h1;
                    if (s.dip_idx == LAST_DIP_IDX) begin // [R09]
                        n.dip_idx = '0;
                        n.step = s.step + 16'h1;
                        n.dur = mss_lerp(s.par[PAR_FIRST],
                            s.par[PAR_LAST], s.step + 16'h1,
                            s.par[PAR_STEPS]); // [R07]
                        if (s.step + 16'h1 >= s.par[PAR_STEPS]) begin // [R08]
                            n.st = ST_DONE;
                        end
                    end
                end
            end
            ST_PAUSED: begin
                if (cmd[CMD_STOP]) begin
                    n.st = ST_IDLE; // [R12]
                end else if (cmd[CMD_RESUME] || s.ms >= PAUSE_MS) begin
                    n.st = ST_SOAK_GAP; // [R11]
                    n.ms = '0;
                end else if (cmd != 16'h0) begin
                    n.ms = '0; // [R11]
                end
            end
            ST_DONE: begin
                if (cmd[CMD_STOP]) begin
                    n.st = ST_IDLE;
                end
            end
            ST_VARIAC: begin
                n.st = ST_VARIAC; // [R16]
            end
            ST_FAULT: begin
                n.st = ST_FAULT; // [R15]
            end
            default: begin
                n.st = ST_FAULT;
                n.down = 1'b1;
                n.load = 1'b0;
                n.sync = 1'b0;
            end
        endcase
        // a stop key during a soak run aborts the dip in progress
        if (cmd[CMD_STOP] && (s.st == ST_SOAK_GAP || s.st == ST_SOAK_ZC
                || s.st == ST_SOAK_DLY || s.st == ST_SOAK_DIP)) begin
            n.st = ST_PAUSED; // [R11]
            n.sync = 1'b0;
            n.load = 1'b1;
            n.ms = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s <= '0;
            s.st <= ST_CHECK;
            s.waitreq <= 1'b1;
            s.par[PAR_DELAY] <= DEF_DELAY; // [R02]
            s.par[PAR_DUR] <= DEF_DUR; // [R02]
            s.par[PAR_INT] <= DEF_INT; // [R05]
            s.par[PAR_FIRST] <= DEF_FIRST; // [R06]
            s.par[PAR_LAST] <= DEF_LAST; // [R07]
            s.par[PAR_STEPS] <= DEF_STEPS; // [R08]
        end else begin
            s <= n;
        end
    end

    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.waitreq;
    assign sync_out = s.sync;
    assign load_on = s.load;
    assign variac_on = s.variac;
    assign err_freq = s.e_freq;
    assign err_overload = s.e_ovl;
    assign shutdown = s.down;
    assign digit_sel = s.digit;

    // ==========================================================
    // checks
    property p_sync_idle;
        @(posedge clock) disable iff (sys_rst)
        s.st == ST_IDLE |-> !sync_out;
    endproperty
    a_sync_idle: assert property (p_sync_idle) // [R01]
        else $error("sync high while idle");

    property p_sync_rise;
        @(posedge clock) disable iff (sys_rst)
        $rose(sync_out) |-> (s.st == ST_SAG_ON || s.st == ST_SOAK_DIP);
    endproperty
    a_sync_rise: assert property (p_sync_rise) // [R01]
        else $error("sync rose outside a sag");

    property p_load_cut;
        @(posedge clock) disable iff (sys_rst)
        sync_out |-> !load_on;
    endproperty
    a_load_cut: assert property (p_load_cut) // [R04]
        else $error("load supplied during a sag");

    property p_err_hold;
        @(posedge clock) disable iff (sys_rst)
        (err_freq || err_overload) |=> (err_freq || err_overload)
            && shutdown && !load_on;
    endproperty
    a_err_hold: assert property (p_err_hold) // [R15]
        else $error("error indication not held");

    property p_variac;
        @(posedge clock) disable iff (sys_rst)
        s.st == ST_VARIAC |=> s.st == ST_VARIAC && variac_on;
    endproperty
    a_variac: assert property (p_variac) // [R16]
        else $error("left variable output mode");

    property p_dur_range;
        @(posedge clock) disable iff (sys_rst)
        s.par[PAR_DUR] >= DUR_MIN && s.par[PAR_DUR] <= DUR_MAX;
    endproperty
    a_dur_range: assert property (p_dur_range) // [R18]
        else $error("sag duration out of range");

    property p_pause_stop;
        @(posedge clock) disable iff (sys_rst)
        (s.st == ST_PAUSED && cmd[CMD_STOP]) |=> s.st == ST_IDLE;
    endproperty
    a_pause_stop: assert property (p_pause_stop) // [R12]
        else $error("stop while paused did not abandon");

    property p_first_dip;
        @(posedge clock) disable iff (sys_rst)
        // a stop key in these two cycles aborts the dip on purpose
        (s.st == ST_SOAK_ZC && zc && s.dip_idx == 5'h0 && !cmd[CMD_STOP])
            ##1 !cmd[CMD_STOP] |=> $rose(sync_out);
    endproperty
    a_first_dip: assert property (p_first_dip) // [R09]
        else $error("first dip not at crossing");

endmodule // mss_top
`default_nettype wire

// *** rtl/mss_pkg.sv ***
package mss_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_NS = 40;
    localparam int MS_NS = 1_000_000;
    localparam int MS_CYC = MS_NS / CLK_NS;
    localparam int US10_NS = 10_000;
    localparam logic [15:0] CYC_PER_10US = 16'(US10_NS / CLK_NS);
    localparam int HZ50_NS = 20_000_000;
    localparam int HZ60_NS = 16_666_667;
    localparam int PER50_CYC = HZ50_NS / CLK_NS;
    localparam int PER60_CYC = HZ60_NS / CLK_NS;
    localparam int PER_TOL_SHIFT = 5;
    localparam logic [23:0] MS_PER_S = 24'h0003e8;
    localparam logic [23:0] PAUSE_MS = 24'h007530;
    localparam logic [23:0] CHECK_MS = 24'h000064;

    // ==========================================================
    // soak sequencing
    localparam logic [4:0] DIPS_PER_STEP = 5'h14;
    localparam logic [4:0] LAST_DIP_IDX = 5'h13;
    localparam logic [4:0] PHASE_INC = 5'h14;

    // ==========================================================
    // parameters: index, first-use value, limits
    localparam int PAR_DELAY = 0;
    localparam int PAR_DUR = 1;
    localparam int PAR_INT = 2;
    localparam int PAR_FIRST = 3;
    localparam int PAR_LAST = 4;
    localparam int PAR_STEPS = 5;
    localparam int NPAR = 6;
    localparam logic [15:0] DEF_DELAY = 16'h01f4;
    localparam logic [15:0] DEF_DUR = 16'h0064;
    localparam logic [15:0] DEF_INT = 16'h000a;
    localparam logic [15:0] DEF_FIRST = 16'h0064;
    localparam logic [15:0] DEF_LAST = 16'h03e8;
    localparam logic [15:0] DEF_STEPS = 16'h00c8;
    localparam logic [15:0] DUR_MIN = 16'h000a;
    localparam logic [15:0] DUR_MAX = 16'h270f;
    localparam logic [15:0] DELAY_MAX = 16'h07d0;
    localparam logic [15:0] PAR_MAX = 16'h270f;
    localparam logic [15:0] STEPS_MIN = 16'h0001;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DELAY = 8'h08;
    localparam logic [7:0] OFS_STEPS = 8'h1c;
    localparam logic [7:0] OFS_DIPS = 8'h20;
    localparam logic [7:0] OFS_TOTAL = 8'h24;
    localparam logic [7:0] OFS_TLEFT = 8'h28;

    // command word bits
    localparam int CMD_SAG = 0;
    localparam int CMD_SOAK = 1;
    localparam int CMD_STOP = 2;
    localparam int CMD_RESUME = 3;
    localparam int CMD_VARIAC = 4;
    localparam int CMD_LEFT = 8;
    localparam int CMD_RIGHT = 9;
    localparam int CMD_UP = 10;
    localparam int CMD_DOWN = 11;
    localparam int CMD_SEL = 12;

    // gray from check through idle into the sag states, and around the soak loop
    typedef enum logic [3:0] {
        ST_CHECK = 4'h0,
        ST_IDLE = 4'h1,
        ST_SAG_WAIT = 4'h3,
        ST_SAG_ON = 4'h2,
        ST_SOAK_GAP = 4'h6,
        ST_SOAK_ZC = 4'h7,
        ST_SOAK_DLY = 4'h5,
        ST_SOAK_DIP = 4'h4,
        ST_DONE = 4'hc,
        ST_PAUSED = 4'hd,
        ST_VARIAC = 4'hf,
        ST_FAULT = 4'he
    } mss_state_t;

endpackage

// *** rtl/mss_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
module mss_tick import mss_pkg::*; #(
    parameter int DIV = MS_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    output logic tick
);

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } mss_tick_t;

    mss_tick_t s, n;

    always_comb begin
        n = s;
        n.tick = 1'b0;
        if (s.cnt == 16'(DIV - 1)) begin
            n.cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = s.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick = s.tick;

endmodule // mss_tick
`default_nettype wire

// *** rtl/mss_zc.sv ***
`timescale 1ns/1ps
`default_nettype none
module mss_zc import mss_pkg::*; #(
    parameter int PER50 = PER50_CYC,
    parameter int PER60 = PER60_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic mains_pol,
    output logic zc,
    output logic [19:0] period,
    output logic freq_ok
);

    typedef struct packed {
        logic prev;
        logic zc;
        logic [19:0] cnt;
        logic [19:0] period;
        logic ok;
    } mss_zc_t;

    mss_zc_t s, n;

    function automatic logic mss_near(input logic [19:0] p, input int nom);
        logic [19:0] c;
        logic [19:0] tol;
        c = 20'(nom);
        tol = c >> PER_TOL_SHIFT;
        return (p >= c - tol) && (p <= c + tol);
    endfunction

    // ==========================================================
    // rising polarity edge marks the crossing; period is edge to edge
    always_comb begin
        n = s;
        n.prev = mains_pol;
        n.zc = 1'b0;
        if (s.cnt != '1) begin
            n.cnt = s.cnt + 20'h00001;
        end
        if (mains_pol && !s.prev) begin // [R19]
            n.zc = 1'b1;
            // the count restarts on the edge cycle, so the span is one more
            n.period = s.cnt + 20'h00001;
            n.cnt = '0;
            n.ok = mss_near(n.period, PER50)
                || mss_near(n.period, PER60); // [R14]
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s <= '0;
            // a pin already high at release must not count as a crossing
            s.prev <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign zc = s.zc;
    assign period = s.period;
    assign freq_ok = s.ok;

    property p_freq_ok;
        @(posedge clock) disable iff (sys_rst)
        freq_ok |-> (mss_near(period, PER50) || mss_near(period, PER60));
    endproperty
    a_freq_ok: assert property (p_freq_ok) // [R14]
        else $error("frequency flagged good outside both windows");

endmodule // mss_zc
`default_nettype wire

// *** verif/mss_mains_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// mains supply and load as seen by the sequencer
module mss_mains_model #(
    parameter int PERIOD = 1000
) (
    input wire logic clock,
    input wire logic fault,
    output logic mains_pol,
    output logic overload
);
    int cnt = 0;
    // the supply runs free; it never stops for the instrument
    always @(posedge clock) begin
        cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        mains_pol <= (cnt < PERIOD / 2);
        overload <= fault;
    end
endmodule // mss_mains_model
`default_nettype wire

// *** verif/tb_mains_sag_timing_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_mains_sag_timing_sequencer import mss_pkg::*;;
    logic clock, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, mains_pol, overload, sync_out, load_on;
    logic variac_on, err_freq, err_overload, shutdown, fault = 1'b0;
    logic [1:0] digit_sel;
    int mismatches = 0, check_count = 0, n;

    // ==========================================================
    // clock, partner and device
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    mss_mains_model #(.PERIOD(200)) i_mains (.clock(clock), .fault(fault),
        .mains_pol(mains_pol), .overload(overload));
    // short counts: 10 cycles a millisecond, so 50 Hz is 200 cycles
    mss_top #(.CYC_PER_MS(10), .PER50(200), .PER60(167)) i_dut (
        .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .mains_pol(mains_pol), .overload(overload), .sync_out(sync_out),
        .load_on(load_on), .variac_on(variac_on), .err_freq(err_freq),
        .err_overload(err_overload), .shutdown(shutdown),
        .digit_sel(digit_sel));

    // ==========================================================
    // bus and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // a released request waits one edge so it never re-rises in one step
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic state_chk(input logic [31:0] exp);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(rd & 32'hf, exp);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================================
    // tests
    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (1100) @(posedge clock);
        rd_chk(OFS_STATUS, 32'h21);
        rd_chk(8'h08, 32'h1f4);
        rd_chk(8'h0c, 32'h64);
        rd_chk(8'h10, 32'ha);
        rd_chk(8'h14, 32'h64);
        rd_chk(8'h18, 32'h3e8);
        rd_chk(8'h1c, 32'hc8);
        rd_chk(8'h24, 32'hfa0);
        $display("defaults done");
        bus(1'b1, 8'h08, 32'h0);
        bus(1'b1, 8'h0c, 32'h14);
        bus(1'b1, OFS_CMD, 32'h1);
        n = 0;
        while (sync_out !== 1'b1 && n < 2000) begin
            @(posedge clock);
            n++;
        end
        n = 0;
        while (sync_out === 1'b1 && load_on === 1'b0 && n < 400) begin
            @(posedge clock);
            n++;
        end
        chk(32'(n), 32'hc8);
        repeat (2) @(posedge clock);
        rd_chk(OFS_STATUS, 32'h21);
        rd_chk(8'h0c, 32'h14);
        $display("single sag done");
        bus(1'b1, 8'h0c, 32'h5);
        rd_chk(8'h0c, 32'ha);
        bus(1'b1, OFS_CMD, 32'h100);
        rd_chk(OFS_STATUS, 32'h421);
        bus(1'b1, OFS_CMD, 32'h1400);
        rd_chk(8'h0c, 32'h14);
        bus(1'b1, OFS_CMD, 32'h1800);
        rd_chk(8'h0c, 32'ha);
        bus(1'b1, 8'h0c, 32'h2710);
        rd_chk(8'h0c, 32'h270f);
        $display("edit done");
        bus(1'b1, 8'h1c, 32'h1);
        rd_chk(8'h24, 32'h14);
        rd_chk(8'h28, 32'hc8);
        bus(1'b1, OFS_CMD, 32'h2);
        bus(1'b1, OFS_CMD, 32'h4);
        state_chk(32'hd);
        bus(1'b1, OFS_CMD, 32'h8);
        state_chk(32'h6);
        bus(1'b1, OFS_CMD, 32'h4);
        bus(1'b1, OFS_CMD, 32'h4);
        state_chk(32'h1);
        // no gap and 1 ms dips, so one step of twenty dips ends in time
        bus(1'b1, 8'h10, 32'h0);
        bus(1'b1, 8'h14, 32'h1);
        bus(1'b1, 8'h18, 32'h1);
        bus(1'b1, OFS_CMD, 32'h2);
        repeat (6000) @(posedge clock);
        rd_chk(OFS_DIPS, 32'h14);
        state_chk(32'hc);
        bus(1'b1, OFS_CMD, 32'h4);
        state_chk(32'h1);
        $display("soak done");
        bus(1'b1, OFS_CMD, 32'h10);
        bus(1'b1, OFS_CMD, 32'h1);
        rd_chk(OFS_STATUS, 32'h44f);
        $display("variac done");
        fault <= 1'b1;
        sys_rst <= 1'b1;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (1100) @(posedge clock);
        bus(1'b1, OFS_CMD, 32'h1);
        rd_chk(OFS_STATUS, 32'h30e);
        $display("fault done");
        end_sim();
    end

    initial begin
        repeat (30000) @(posedge clock);
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
endmodule // tb_mains_sag_timing_sequencer
`default_nettype wire
